// *** include/lss_pkg.sv ***
// constants, command codes and reset values of the serial switch control
// assumes a 100 MHz core clock and a 24-bit serial frame from the mcu
//
// Contract
// - overtemperature turns off only the hot output and sets the any-fault bit
// - a cooled output stays off unless thermal retry bit is one
// - frame bits 23..18 are opcode, bits 15..0 per-output values
// - a command takes effect only at the rising edge of chip select
// - seven opcodes: on/off, pulldown, recovery, fast short, pulse, combine, reset
// - on/off command stores sixteen low bits, one means output on
// - pulldown enables cleared by power-on reset, reset pin and reset command
// - no off-state open-load fault while that output's pulldown is off
// - after overvoltage outputs stay off unless recovery bit is one
// - fast short bit zero shuts output after sustained high drain voltage
// - power-on values all zero except fast short select all ones
// - pulse select one drives output from shared pulse pin and on/off bit
// - pulse select zero uses dedicated pulse input and on/off bit
// - fault word: any-fault, overvoltage, six zeros, sixteen output faults
// - combine zero ands shared pulse with on/off, one ors them
// - reset command turns outputs off and restores power-on values
// - latched faults clear at each chip select rising edge
// - both words travel most significant bit first, 24 bits each
package lss_pkg;
  localparam int NCH = 16;
  localparam int WORD_W = 24;
  localparam int CNT_W = 5;
  localparam int TMR_W = 16;
  localparam int OPC_HI = 23;
  localparam int OPC_LO = 18;
  localparam int TH_RECOV_BIT = 1;
  localparam int OV_RECOV_BIT = 0;
  localparam int FRAME_TH_BIT = 17;
  localparam int FRAME_OV_BIT = 16;
  localparam int FLT_ANY_BIT = 23;
  localparam int FLT_OV_BIT = 22;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
  localparam logic [15:0] ONOFF_RST = 16'h0000;
  localparam logic [15:0] PULLDOWN_RST = 16'h0000;
  localparam logic [1:0] RECOV_RST = 2'h0;
  localparam logic [15:0] FSS_RST = 16'hffff;
  localparam logic [15:0] PSEL_RST = 16'h0000;
  localparam logic [15:0] COMB_RST = 16'h0000;
  // outputs that own a dedicated parallel pulse input
  localparam logic [15:0] DIRECT_MASK = 16'hc3c3;
  localparam int CLK_MHZ = 100;
  localparam int SHORT_FILTER_US = 100;
  localparam int OL_DELAY_US = 100;
  localparam int SHORT_FILTER_CYC_DEF = SHORT_FILTER_US * CLK_MHZ;
  localparam int OL_DELAY_CYC_DEF = OL_DELAY_US * CLK_MHZ;
  typedef enum logic [5:0] {
    OPC_ONOFF = 6'h00,
    OPC_PULLDOWN = 6'h01,
    OPC_RECOVERY = 6'h02,
    OPC_FASTSHORT = 6'h03,
    OPC_PULSESEL = 6'h04,
    OPC_COMBINE = 6'h05,
    OPC_RESET = 6'h06
  } opcode_t;
endpackage : lss_pkg

// *** include/frame_if.sv ***
// signals between the serial link domain and the core domain
// word and full change only on the link clock, so_bit also clears at chip select high; snap only on the core
`timescale 1ns/1ns
`default_nettype none
interface frame_if;
  logic [23:0] word;
  logic full;
  logic so_bit;
  logic started;
  logic [23:0] snap;
  modport link (output word, output full, output so_bit, output started,
    input snap);
  modport core (input word, input full, input so_bit, input started,
    output snap);
endinterface : frame_if
`default_nettype wire

// *** src/bit_sync.sv ***
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level or a bit stable across the crossing
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_t;
  sync_t st_r;
  sync_t st_nxt;
  always_comb begin
    st_nxt.meta = d;
    st_nxt.sync = st_r.meta;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.sync;
endmodule : bit_sync
`default_nettype wire

// *** src/spi_link.sv ***
// serial shifter on the link clock: captures command, returns fault word
// assumes input sampled on rising and output changed on falling link clock
`timescale 1ns/1ns
`default_nettype none
module spi_link
  import lss_pkg::*;
(
  input wire logic sclk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic si,
  frame_if.link fr
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] sh;
  } rise_t;
  typedef struct packed {
    logic started;
    logic so_bit;
  } fall_t;
  rise_t r_r;
  rise_t r_nxt;
  fall_t f_r;
  logic idle_r;

  // -------------------------------------------------------------------
  // shift in msb first, first edge loads the fault snapshot
  // -------------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    if (idle_r) begin
      r_nxt.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
      r_nxt.sh = {fr.snap[WORD_W-2:0], si};
    end else begin
      r_nxt.sh = {r_r.sh[WORD_W-2:0], si};
      if (r_r.cnt != FRAME_BITS) begin
        r_nxt.cnt = r_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // idle is preset by chip select high, cleared by the first edge
  always_ff @(posedge sclk or posedge cs_n or negedge arst_n) begin
    if (!arst_n) begin
      idle_r <= 1'b1;
    end else if (cs_n) begin
      idle_r <= 1'b1;
    end else begin
      idle_r <= 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge cs_n or negedge arst_n) begin
    if (!arst_n) begin
      f_r <= '0;
    end else if (cs_n) begin
      f_r <= '0;
    end else begin
      f_r <= {1'b1, r_r.sh[WORD_W-1]};
    end
  end

  assign fr.word = r_r.sh;
  assign fr.full = (r_r.cnt == FRAME_BITS);
  assign fr.so_bit = f_r.so_bit;
  assign fr.started = f_r.started;
endmodule : spi_link
`default_nettype wire

// *** src/low_side_switch_spi_control.sv ***
// command decoder and output logic of a 16-channel low-side switch
// assumes all pins are asynchronous to core_clk; sclk is the link clock
`timescale 1ns/1ns
`default_nettype none
module low_side_switch_spi_control
  import lss_pkg::*;
#(
  parameter int SHORT_FILTER_CYC = SHORT_FILTER_CYC_DEF,
  parameter int OL_DELAY_CYC = OL_DELAY_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reset_pin_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic shared_pulse,
  input wire logic [lss_pkg::NCH-1:0] direct_pulse_input,
  input wire logic [lss_pkg::NCH-1:0] over_temp,
  input wire logic over_voltage,
  input wire logic [lss_pkg::NCH-1:0] vds_high,
  input wire logic [lss_pkg::NCH-1:0] open_load_cmp,
  output logic [lss_pkg::NCH-1:0] driver_channel,
  output logic [lss_pkg::NCH-1:0] pulldown_en
);
  import lss_pkg::*;

  localparam int SYNC_W = 4 * NCH + 6;

  if (SHORT_FILTER_CYC < 1 || SHORT_FILTER_CYC >= 2 ** TMR_W) begin : g_chk1
    $error("short filter count out of range");
  end
  if (OL_DELAY_CYC < 1 || OL_DELAY_CYC >= 2 ** TMR_W) begin : g_chk2
    $error("open load delay count out of range");
  end

  typedef struct packed {
    logic [NCH-1:0] on_off;
    logic [NCH-1:0] pd_en;
    logic [1:0] recov;
    logic [NCH-1:0] fss;
    logic [NCH-1:0] psel;
    logic [NCH-1:0] comb;
    logic [NCH-1:0] flt;
    logic ov_flt;
    logic [NCH-1:0] th_off;
    logic [NCH-1:0] sc_off;
    logic [NCH-1:0][TMR_W-1:0] sc_tmr;
    logic [TMR_W-1:0] ol_tmr;
    logic ov_prev;
    logic cs_n_prev;
    logic [WORD_W-1:0] snap;
    logic [NCH-1:0] drv;
    logic so;
    logic so_oe;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  frame_if fr ();

  logic [SYNC_W-1:0] sync_q;
  logic rst_s_n;
  logic cs_n_s;
  logic pulse_s;
  logic ov_s;
  logic started_s;
  logic so_bit_s;
  logic [NCH-1:0] direct_s;
  logic [NCH-1:0] ot_s;
  logic [NCH-1:0] vds_s;
  logic [NCH-1:0] olc_s;
  logic cs_rise;
  logic cmd_ok;
  logic ov_recover;
  logic [NCH-1:0] cmd;
  logic [NCH-1:0] sc_set;
  logic [NCH-1:0] ol_set;
  logic [WORD_W-1:0] fault_word;

  // -------------------------------------------------------------------
  // crossings
  // -------------------------------------------------------------------
  bit_sync #(
    .W(SYNC_W),
    .RST_VAL({2'b11, {(SYNC_W-2){1'b0}}})
  ) u_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d({reset_pin_n, cs_n, shared_pulse, over_voltage, fr.started,
      fr.so_bit, direct_pulse_input, over_temp, vds_high, open_load_cmp}),
    .q(sync_q)
  );

  assign {rst_s_n, cs_n_s, pulse_s, ov_s, started_s, so_bit_s, direct_s,
    ot_s, vds_s, olc_s} = sync_q;

  spi_link u_link (
    .sclk(sclk),
    .arst_n(arst_n),
    .cs_n(cs_n),
    .si(si),
    .fr(fr)
  );

  // snapshot is frozen while a frame is open, so the link sees it steady
  assign fr.snap = st_r.snap;

  // -------------------------------------------------------------------
  // drive selection per output
  // -------------------------------------------------------------------
  function automatic logic [NCH-1:0] drive_cmd(
    input logic [NCH-1:0] on_off,
    input logic [NCH-1:0] psel,
    input logic [NCH-1:0] comb,
    input logic pulse,
    input logic [NCH-1:0] direct
  );
    logic [NCH-1:0] shared_and;
    logic [NCH-1:0] shared_or;
    logic [NCH-1:0] direct_or;
    shared_and = on_off & {NCH{pulse}};
    shared_or = on_off | {NCH{pulse}};
    direct_or = on_off | (direct & DIRECT_MASK);
    drive_cmd = (psel & ((comb & shared_or) | (~comb & shared_and))) |
      (~psel & direct_or);
  endfunction : drive_cmd

  function automatic logic [NCH-1:0] low16(input logic [WORD_W-1:0] w);
    low16 = w[NCH-1:0];
  endfunction : low16

  assign cs_rise = cs_n_s && !st_r.cs_n_prev;
  assign cmd_ok = cs_rise && fr.full;
  assign ov_recover = st_r.ov_prev && !ov_s;
  assign cmd = drive_cmd(st_r.on_off, st_r.psel, st_r.comb, pulse_s, direct_s);
  assign fault_word = {st_r.flt != '0 || st_r.ov_flt, st_r.ov_flt, 6'h00,
    st_r.flt};

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      sc_set[i] = st_r.sc_tmr[i] == TMR_W'(SHORT_FILTER_CYC - 1);
    end
  end

  // off-state open load only with pulldown on and the delay run out
  assign ol_set = st_r.pd_en & ~st_r.drv & olc_s &
    {NCH{st_r.ol_tmr == '0}};

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_n_prev = cs_n_s;
    st_nxt.ov_prev = ov_s;

    // thermal latch: cleared on cool with retry, or when commanded off
    st_nxt.th_off = ot_s | (st_r.th_off & cmd &
      ~({NCH{st_r.recov[TH_RECOV_BIT]}} & ~ot_s));

    // fast short filter per output
    for (int i = 0; i < NCH; i++) begin
      if (!st_r.fss[i] && cmd[i] && vds_s[i] && !st_r.sc_off[i]) begin
        st_nxt.sc_tmr[i] = st_r.sc_tmr[i] + 16'h0001;
      end else begin
        st_nxt.sc_tmr[i] = '0;
      end
    end
    st_nxt.sc_off = (st_r.sc_off & cmd) | (sc_set & ~st_r.fss);

    if (cs_rise) begin
      st_nxt.ol_tmr = TMR_W'(OL_DELAY_CYC);
    end else if (st_r.ol_tmr != '0) begin
      st_nxt.ol_tmr = st_r.ol_tmr - 16'h0001;
    end

    // set wins over the clear at chip select rise
    st_nxt.flt = (cs_rise ? '0 : st_r.flt) | ot_s | sc_set | ol_set;
    st_nxt.ov_flt = (cs_rise ? 1'b0 : st_r.ov_flt) | ov_s;

    if (ov_recover && !st_r.recov[OV_RECOV_BIT]) begin
      st_nxt.on_off = '0;
    end

    if (cmd_ok) begin
      case (fr.word[OPC_HI:OPC_LO])
        OPC_ONOFF: begin
          st_nxt.on_off = low16(fr.word);
        end
        OPC_PULLDOWN: begin
          st_nxt.pd_en = low16(fr.word);
        end
        OPC_RECOVERY: begin
          st_nxt.recov = {fr.word[FRAME_TH_BIT], fr.word[FRAME_OV_BIT]};
        end
        OPC_FASTSHORT: begin
          st_nxt.fss = low16(fr.word);
        end
        OPC_PULSESEL: begin
          st_nxt.psel = low16(fr.word);
        end
        OPC_COMBINE: begin
          st_nxt.comb = low16(fr.word);
        end
        default: begin
        end
      endcase
    end

    // outputs follow the command unless a protection holds them off
    st_nxt.drv = cmd & ~ot_s & ~st_r.th_off & ~st_r.sc_off &
      {NCH{!ov_s}};

    st_nxt.snap = cs_n_s ? fault_word : st_r.snap;
    st_nxt.so_oe = !cs_n_s;
    st_nxt.so = !cs_n_s && (started_s ? so_bit_s : st_r.snap[FLT_ANY_BIT]);

    if (!rst_s_n || (cmd_ok && fr.word[OPC_HI:OPC_LO] == OPC_RESET)) begin
      st_nxt.on_off = ONOFF_RST;
      st_nxt.pd_en = PULLDOWN_RST;
      st_nxt.recov = RECOV_RST;
      st_nxt.fss = FSS_RST;
      st_nxt.psel = PSEL_RST;
      st_nxt.comb = COMB_RST;
      st_nxt.th_off = '0;
      st_nxt.sc_off = '0;
      st_nxt.sc_tmr = '0;
      st_nxt.flt = '0;
      st_nxt.ov_flt = 1'b0;
      st_nxt.drv = '0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.fss <= FSS_RST;
      st_r.cs_n_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign so = st_r.so;
  assign so_oe = st_r.so_oe;
  assign driver_channel = st_r.drv;
  assign pulldown_en = st_r.pd_en;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  logic [5:0] opc;
  assign opc = fr.word[OPC_HI:OPC_LO];

  property p_ot_off;
    @(posedge core_clk) disable iff (!arst_n)
      (ot_s != '0) |=> ((driver_channel & $past(ot_s)) == '0);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("hot output driven");

  property p_ot_any;
    @(posedge core_clk) disable iff (!arst_n)
      (ot_s != '0 && rst_s_n) |=> st_r.flt != '0 ##1 fault_word[FLT_ANY_BIT];
  endproperty
  a_ot_any: assert property (p_ot_any) else $error("any-fault not set");

  property p_th_keep;
    @(posedge core_clk) disable iff (!arst_n)
      (st_r.th_off != '0 && !st_r.recov[TH_RECOV_BIT])
        |=> ((driver_channel & $past(st_r.th_off)) == '0);
  endproperty
  a_th_keep: assert property (p_th_keep) else $error("latched output on");

  property p_cmd_edge;
    @(posedge core_clk) disable iff (!arst_n)
      (!cs_rise && rst_s_n && !ov_recover) |=> $stable(st_r.on_off);
  endproperty
  a_cmd_edge: assert property (p_cmd_edge) else $error("on/off moved");

  property p_onoff;
    @(posedge core_clk) disable iff (!arst_n)
      (cmd_ok && rst_s_n && opc == OPC_ONOFF)
        |=> st_r.on_off == $past(fr.word[NCH-1:0]);
  endproperty
  a_onoff: assert property (p_onoff) else $error("on/off not stored");

  property p_pd_reset;
    @(posedge core_clk) disable iff (!arst_n)
      !rst_s_n |=> pulldown_en == '0 && driver_channel == '0;
  endproperty
  a_pd_reset: assert property (p_pd_reset) else $error("reset pin ignored");

  property p_ol_gate;
    @(posedge core_clk) disable iff (!arst_n)
      ((st_nxt.flt & ~st_r.flt & ~st_r.pd_en & ~ot_s & ~sc_set) == '0);
  endproperty
  a_ol_gate: assert property (p_ol_gate) else $error("open load unmasked");

  property p_ov_off;
    @(posedge core_clk) disable iff (!arst_n)
      ov_s |=> driver_channel == '0 ##1 fault_word[FLT_OV_BIT];
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("output on in ov");

  property p_word_zero;
    @(posedge core_clk) disable iff (!arst_n)
      fault_word[21:16] == 6'h00;
  endproperty
  a_word_zero: assert property (p_word_zero) else $error("reserved bits");

  property p_reset_cmd;
    @(posedge core_clk) disable iff (!arst_n)
      (cmd_ok && opc == OPC_RESET)
        |=> st_r.fss == FSS_RST && st_r.on_off == '0 ##1 driver_channel == '0;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset cmd");

  property p_clear;
    @(posedge core_clk) disable iff (!arst_n)
      (cs_rise && ot_s == '0 && sc_set == '0 && ol_set == '0 && !ov_s)
        |=> st_r.flt == '0 && !st_r.ov_flt;
  endproperty
  a_clear: assert property (p_clear) else $error("faults not cleared");

  property p_bad_opc;
    @(posedge core_clk) disable iff (!arst_n)
      (cmd_ok && rst_s_n && opc > OPC_RESET) |=> $stable(st_r.psel) &&
        $stable(st_r.comb) && $stable(st_r.pd_en);
  endproperty
  a_bad_opc: assert property (p_bad_opc) else $error("bad opcode acted");

  c_onoff: cover property (@(posedge core_clk) disable iff (!arst_n)
    cmd_ok && opc == OPC_ONOFF);
  c_pulse: cover property (@(posedge core_clk) disable iff (!arst_n)
    (st_r.psel & driver_channel) != '0);
  c_short: cover property (@(posedge core_clk) disable iff (!arst_n)
    sc_set != '0);
  c_ol: cover property (@(posedge core_clk) disable iff (!arst_n)
    ol_set != '0);
endmodule : low_side_switch_spi_control
`default_nettype wire

// *** dv/spi_mcu_model.sv ***
// serial master standing in for the mcu: sends one command word per frame
// assumes so is valid at each sclk rise; sclk idles low between frames
`timescale 1ns/1ns
`default_nettype none
module spi_mcu_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // --------------------------------------------------------------
  // one frame: nbits shifted each way, then chip select released
  // --------------------------------------------------------------
  task automatic xfer(input logic [23:0] cmd, input int nbits,
                      output logic [23:0] resp);
    resp = '0;
    #7 cs_n = 1'b0;
    #100;
    for (int i = 0; i < nbits; i++) begin
      si = cmd[23-i];
      #80 sclk = 1'b1;
      resp = {resp[22:0], so};
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    // released data line must not keep showing the last bit
    si = ~si;
    #200;
  endtask : xfer
endmodule : spi_mcu_model
`default_nettype wire

// *** dv/low_side_switch_spi_control_tb.sv ***
// self-checking bench of the serial switch control
// assumes the mcu model drives the link; core inputs change at core_clk rise
`timescale 1ns/1ns
`default_nettype none
module low_side_switch_spi_control_tb;
  import lss_pkg::*;
  logic core_clk, arst_n, reset_pin_n, shared_pulse, over_voltage;
  logic [15:0] direct_pulse_input, over_temp, vds_high, open_load_cmp;
  logic [15:0] driver_channel, pulldown_en;
  logic [23:0] rsp;
  wire sclk, cs_n, si, so, so_oe;
  int failures, num_checks;

  low_side_switch_spi_control #(.SHORT_FILTER_CYC(8), .OL_DELAY_CYC(8)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .shared_pulse(shared_pulse), .direct_pulse_input(direct_pulse_input),
    .over_temp(over_temp), .over_voltage(over_voltage),
    .vds_high(vds_high), .open_load_cmp(open_load_cmp),
    .driver_channel(driver_channel), .pulldown_en(pulldown_en));

  spi_mcu_model mcu (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk24(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk24

  task automatic cmd(input logic [5:0] op, input logic [17:0] val);
    mcu.xfer({op, val}, 24, rsp);
    wait_cyc(8);
  endtask : cmd

  function automatic logic [15:0] drive_exp(input logic [15:0] on,
    input logic [15:0] ps, input logic [15:0] cb, input logic p,
    input logic [15:0] d);
    logic [15:0] pv;
    pv = {16{p}};
    return (ps & ((cb & (pv | on)) | (~cb & pv & on))) |
      (~ps & (on | (d & DIRECT_MASK)));
  endfunction : drive_exp

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    failures = 0;
    num_checks = 0;
    arst_n = 1'b0;
    reset_pin_n = 1'b1;
    shared_pulse = 1'b0;
    over_voltage = 1'b0;
    direct_pulse_input = '0;
    over_temp = '0;
    vds_high = '0;
    open_load_cmp = '0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    wait_cyc(5);
    chk16("drive after reset", 16'h0000, driver_channel);
    chk16("pulldown after reset", 16'h0000, pulldown_en);
    chk16("so idle", 16'h0000, {14'h0000, so_oe, so});
    $display("test reset done");

    // so enable must rise well before the first link clock edge
    fork
      cmd(OPC_ONOFF, 18'h3a5c3);
      begin
        wait_cyc(12);
        chk16("so enable", 16'h0001, {15'h0000, so_oe});
      end
    join
    chk16("drive on/off", 16'ha5c3, driver_channel);
    mcu.xfer({OPC_ONOFF, 18'h0ffff}, 16, rsp);
    wait_cyc(8);
    chk16("drive short frame", 16'ha5c3, driver_channel);
    cmd(6'h07, 18'h0ffff);
    chk16("drive bad opcode", 16'ha5c3, driver_channel);
    cmd(OPC_PULLDOWN, 18'h000ff);
    chk16("pulldown", 16'h00ff, pulldown_en);
    $display("test commands done");

    cmd(OPC_ONOFF, 18'h00f0f);
    cmd(OPC_PULSESEL, 18'h0ff00);
    cmd(OPC_COMBINE, 18'h0f0f0);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      shared_pulse <= k[0];
      direct_pulse_input <= {16{k[1]}};
      wait_cyc(6);
      chk16("drive pulse", drive_exp(16'h0f0f, 16'hff00, 16'hf0f0, k[0],
        {16{k[1]}}), driver_channel);
    end
    @(posedge core_clk);
    shared_pulse <= 1'b0;
    direct_pulse_input <= '0;
    cmd(OPC_PULSESEL, 18'h00000);
    $display("test pulse done");

    cmd(OPC_ONOFF, 18'h0ffff);
    @(posedge core_clk) over_temp <= 16'h0008;
    wait_cyc(8);
    chk16("drive hot", 16'hfff7, driver_channel);
    cmd(OPC_ONOFF, 18'h0ffff);
    chk24("fault hot", 24'h800008, rsp);
    @(posedge core_clk) over_temp <= 16'h0000;
    wait_cyc(8);
    chk16("drive cooled", 16'hfff7, driver_channel);
    cmd(OPC_RECOVERY, 18'h20000);
    @(posedge core_clk) over_temp <= 16'h0020;
    wait_cyc(8);
    chk16("ch5 hot", 16'h0000, driver_channel & 16'h0020);
    @(posedge core_clk) over_temp <= 16'h0000;
    wait_cyc(8);
    chk16("ch5 retry", 16'h0020, driver_channel & 16'h0020);
    $display("test thermal done");

    cmd(OPC_RESET, 18'h3ffff);
    chk16("drive reset cmd", 16'h0000, driver_channel);
    chk16("pulldown reset cmd", 16'h0000, pulldown_en);
    cmd(OPC_PULLDOWN, 18'h00100);
    @(posedge core_clk) open_load_cmp <= 16'h0104;
    wait_cyc(30);
    @(posedge core_clk) open_load_cmp <= 16'h0000;
    wait_cyc(8);
    cmd(OPC_PULLDOWN, 18'h00100);
    chk24("fault open", 24'h800100, rsp);
    cmd(OPC_PULLDOWN, 18'h00100);
    chk24("fault cleared", 24'h000000, rsp);
    $display("test open load done");

    cmd(OPC_ONOFF, 18'h00003);
    @(posedge core_clk) vds_high <= 16'h0003;
    wait_cyc(40);
    chk16("drive thermal only", 16'h0003, driver_channel);
    cmd(OPC_FASTSHORT, 18'h0fffe);
    wait_cyc(40);
    chk16("drive short", 16'h0002, driver_channel);
    @(posedge core_clk) vds_high <= 16'h0000;
    cmd(OPC_ONOFF, 18'h00000);
    chk24("fault short", 24'h800001, rsp);
    $display("test short done");

    cmd(OPC_RESET, 18'h00000);
    cmd(OPC_ONOFF, 18'h00011);
    cmd(OPC_RECOVERY, 18'h10000);
    @(posedge core_clk) over_voltage <= 1'b1;
    wait_cyc(10);
    chk16("drive overvoltage", 16'h0000, driver_channel);
    cmd(OPC_ONOFF, 18'h00011);
    chk24("fault overvoltage", 24'hc00000, rsp);
    @(posedge core_clk) over_voltage <= 1'b0;
    wait_cyc(10);
    chk16("drive restored", 16'h0011, driver_channel);
    cmd(OPC_RECOVERY, 18'h00000);
    @(posedge core_clk) over_voltage <= 1'b1;
    wait_cyc(10);
    @(posedge core_clk) over_voltage <= 1'b0;
    wait_cyc(10);
    chk16("drive kept off", 16'h0000, driver_channel);
    $display("test overvoltage done");

    cmd(OPC_ONOFF, 18'h0ffff);
    cmd(OPC_PULLDOWN, 18'h0ffff);
    @(posedge core_clk) reset_pin_n <= 1'b0;
    wait_cyc(6);
    chk16("drive reset pin", 16'h0000, driver_channel);
    chk16("pulldown reset pin", 16'h0000, pulldown_en);
    @(posedge core_clk) reset_pin_n <= 1'b1;
    wait_cyc(6);
    $display("test reset pin done");
    report_and_stop();
  end
endmodule : low_side_switch_spi_control_tb
`default_nettype wire
